// *** hdl/afecr_pkg.sv ***
// Constants shared by the control bank of the imaging front end.
// Assumes the serial pins are sampled by the bank's own clock (master clock).
package afecr_pkg;

    localparam int ADDR_W  = 6;
    localparam int DATA_W  = 8;
    localparam int SHIFT_W = ADDR_W + DATA_W;
    localparam int PIX_W   = 16;

    // Register addresses
    localparam logic [5:0] ADDR_PWR   = 6'h01;
    localparam logic [5:0] ADDR_OUT   = 6'h02;
    localparam logic [5:0] ADDR_CLAMP = 6'h03;
    localparam logic [5:0] ADDR_SRST  = 6'h04;
    localparam logic [5:0] ADDR_CCOL  = 6'h06;
    localparam logic [5:0] ADDR_REV   = 6'h07;
    localparam logic [5:0] ADDR_SYNC  = 6'h08;
    localparam logic [5:0] ADDR_TEST  = 6'h09;
    localparam logic [5:0] ADDR_RSVA  = 6'h0A;
    localparam logic [5:0] ADDR_RSVB  = 6'h0B;
    localparam logic [5:0] ADDR_RSVC  = 6'h0C;
    localparam logic [5:0] ADDR_ROFF  = 6'h20;
    localparam logic [5:0] ADDR_GOFF  = 6'h21;
    localparam logic [5:0] ADDR_BOFF  = 6'h22;
    localparam logic [5:0] ADDR_AOFF  = 6'h23;
    localparam logic [5:0] ADDR_RGAIN = 6'h28;
    localparam logic [5:0] ADDR_GGAIN = 6'h29;
    localparam logic [5:0] ADDR_BGAIN = 6'h2A;
    localparam logic [5:0] ADDR_AGAIN = 6'h2B;

    // Reset values
    localparam logic [7:0] RST_PWR   = 8'h0F;
    localparam logic [7:0] RST_OUT   = 8'h23;
    localparam logic [7:0] RST_CLAMP = 8'h1F;
    localparam logic [7:0] RST_CCOL  = 8'h05;
    localparam logic [7:0] RST_ZERO  = 8'h00;
    localparam logic [7:0] RST_OFF   = 8'h80;

    // Stored registers, index 0 first
    localparam int NREG = 15;
    localparam int IDX_PWR   = 0;
    localparam int IDX_OUT   = 1;
    localparam int IDX_CLAMP = 2;
    localparam int IDX_ROFF  = 9;
    localparam int IDX_GOFF  = 10;
    localparam int IDX_BOFF  = 11;
    localparam int IDX_RGAIN = 12;
    localparam int IDX_GGAIN = 13;
    localparam int IDX_BGAIN = 14;

    localparam logic [NREG-1:0][5:0] REG_ADDR = {
        ADDR_BGAIN, ADDR_GGAIN, ADDR_RGAIN, ADDR_BOFF, ADDR_GOFF, ADDR_ROFF,
        ADDR_RSVC, ADDR_RSVB, ADDR_RSVA, ADDR_TEST, ADDR_SYNC, ADDR_CCOL,
        ADDR_CLAMP, ADDR_OUT, ADDR_PWR};
    localparam logic [NREG-1:0][7:0] REG_RST = {
        RST_ZERO, RST_ZERO, RST_ZERO, RST_OFF, RST_OFF, RST_OFF,
        RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_CCOL,
        RST_CLAMP, RST_OUT, RST_PWR};

    // Field positions
    localparam int READ_FLAG_BIT = 4;
    localparam int BCAST_LSB     = 2;
    localparam int PWR_EN_BIT    = 0;
    localparam int PWR_DUAL_BIT  = 1;
    localparam int PWR_OFS_LSB   = 4;
    localparam int PWR_MAX_BIT   = 6;
    localparam int OUT_INV_BIT   = 2;
    localparam int OUT_EXT_BIT   = 3;
    localparam int OUT_RNG_BIT   = 5;
    localparam int OUT_LAT_LSB   = 6;
    localparam int CLAMP_LVL_LSB = 0;

    // Timing: master-clock periods per ADC clock period, then the last read-back bit index and the full-scale code
    localparam logic [1:0] ADC_DIV_NORMAL = 2'h2;
    localparam logic [1:0] ADC_DIV_MODE2  = 2'h3;
    localparam logic [3:0] READ_LAST_BIT  = 4'h7;
    localparam logic [PIX_W-1:0] FULL_SCALE = 16'hFFFF;

    typedef enum logic {
        AFECR_SER_IDLE = 1'b0,
        AFECR_SER_READ = 1'b1
    } afecr_ser_t;

endpackage

// *** hdl/afecr_latency_line.sv ***
// Output latency line: holds up to DEPTH past samples, one per ADC tick.
// Assumes shift_en is a one-cycle pulse on the same clock.
`timescale 1ns/1ns
`default_nettype none
module afecr_latency_line #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 3
) (
    input  wire logic             clk,
    input  wire logic             rst_n_sync,
    input  wire logic             shift_en,
    input  wire logic             hold_zero,
    input  wire logic [1:0]       sel,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] stage;
        logic [WIDTH-1:0]            dout;
    } afecr_line_t;

    afecr_line_t st_r;
    afecr_line_t st_nxt;
    logic [DEPTH:0][WIDTH-1:0] tap;

    assign tap[0] = din;
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++)
        begin : g_tap
            assign tap[g+1] = st_r.stage[g];
        end
    endgenerate

    always_comb
    begin
        st_nxt = st_r;
        if (shift_en)
        begin
            st_nxt.stage = {st_r.stage[DEPTH-2:0], din};
        end
        // Powered-down device shows a quiet bus rather than stale data
        st_nxt.dout = hold_zero ? '0 : tap[sel];
    end

    always_ff @(posedge clk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign dout = st_r.dout;

endmodule
`default_nettype wire

// *** hdl/afecr_control_bank.sv ***
// Control register bank of a single-channel imaging front end, with serial
// write/read-back port, output inversion and programmable output latency.
// Assumes clk is the master clock; serial pins come from another domain.
// Contract
// - Host writes codes to six-bit addresses; device applies each to its register.
// - Power register bit 0: 0 powers down, 1 active; resets to 1.
// - Power register bit 1: 0 single-ended, 1 double sampling; resets to 1.
// - Bits 5:4 set amplifier zero-input offset: 0, 0, +full, -full.
// - Bit 6 set only in maximum-speed mode, else cleared.
// - Output register bit 2 inverts output code polarity; default clear.
// - Inverted output equals 65535 minus the clipped result.
// - Output register bit 3 powers down clamp DAC, output high impedance.
// - Output register bit 5 selects clamp DAC range; default 1.
// - Bits 7:6 add zero to three ADC periods of output latency; here the first step adds one master clock only, each later step one ADC period.
// - ADC period is two master clocks, three in fast second mode.
// - Any write to address 000100 resets all registers to defaults.
// - Address bit 4 set requests read-back, shifted out MSB first on falling edges.
`timescale 1ns/1ns
`default_nettype none
module afecr_control_bank
    import afecr_pkg::*;
#(
    parameter logic [7:0] REVISION_ID = 8'h5A  // Arbitrary value
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             sck,
    input  wire logic             serial_in,
    input  wire logic             serial_load_strobe,
    input  wire logic             mode2_select,
    input  wire logic [PIX_W-1:0] conv_result,
    output logic                  serial_out,
    output logic                  serial_out_oe,
    output logic                  power_enable,
    output logic                  dual_sample_select,
    output logic      [1:0]       amp_output_offset_sel,
    output logic                  max_speed_mode_sel,
    output logic                  output_polarity_invert,
    output logic                  clamp_ref_external,
    output logic                  clamp_dac_range,
    output logic      [1:0]       output_latency_sel,
    output logic      [3:0]       clamp_level_code,
    output logic      [7:0]       red_offset_code,
    output logic      [7:0]       green_offset_code,
    output logic      [7:0]       blue_offset_code,
    output logic      [7:0]       red_gain_code,
    output logic      [7:0]       green_gain_code,
    output logic      [7:0]       blue_gain_code,
    output logic                  adc_tick,
    output logic      [PIX_W-1:0] pixel_data
);

    typedef struct packed {
        logic [NREG-1:0][7:0] regs;
        logic [2:0]           sck_s;
        logic [2:0]           sen_s;
        logic [1:0]           sin_s;
        logic [1:0]           mode2_s;
        logic [SHIFT_W-1:0]   shift_in;
        afecr_ser_t           ser;
        logic [7:0]           shift_out;
        logic [3:0]           out_cnt;
        logic                 serial_out;
        logic                 serial_out_oe;
        logic [1:0]           adc_cnt;
        logic                 adc_tick;
    } afecr_state_t;

    // Registers sit in the top bits; every other field, the serial state included, starts at 0
    localparam afecr_state_t RST_STATE =
        afecr_state_t'({REG_RST, {($bits(afecr_state_t) - NREG * 8){1'b0}}});

    logic [1:0]       rst_sync_r;
    logic             rst_n_sync;
    afecr_state_t     st_r;
    afecr_state_t     st_nxt;
    logic             sck_rise;
    logic             sck_fall;
    logic             sen_rise;
    logic [5:0]       cmd_addr;
    logic [7:0]       cmd_data;
    logic [5:0]       reg_addr;
    logic             wr_go;
    logic             rd_go;
    logic             srst_go;
    logic [7:0]       read_val;
    logic [1:0]       adc_div;
    logic [PIX_W-1:0] line_din;

    // Reset is released through two flops so every flop leaves reset together
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_sync_r <= 2'h0;
        end
        else
        begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n_sync = rst_sync_r[1];

    // Edges use only the second and third sampling stages
    assign sck_rise = st_r.sck_s[1] & ~st_r.sck_s[2];
    assign sck_fall = ~st_r.sck_s[1] & st_r.sck_s[2];
    assign sen_rise = st_r.sen_s[1] & ~st_r.sen_s[2];

    assign cmd_addr = st_r.shift_in[SHIFT_W-1:DATA_W];
    assign cmd_data = st_r.shift_in[DATA_W-1:0];
    assign reg_addr = cmd_addr & ~(6'h01 << READ_FLAG_BIT);
    assign rd_go    = sen_rise & cmd_addr[READ_FLAG_BIT];
    assign wr_go    = sen_rise & ~cmd_addr[READ_FLAG_BIT];
    assign srst_go  = wr_go & (cmd_addr == ADDR_SRST);

    // Read-back value; write-only and unmapped addresses read as zero
    always_comb
    begin
        read_val = (reg_addr == ADDR_REV) ? REVISION_ID : 8'h00;
        for (int i = 0; i < NREG; i++)
        begin
            if (reg_addr == REG_ADDR[i])
            begin
                read_val = st_r.regs[i];
            end
        end
    end

    assign adc_div = st_r.mode2_s[1] ? ADC_DIV_MODE2 : ADC_DIV_NORMAL;
    assign line_din = st_r.regs[IDX_OUT][OUT_INV_BIT]
                    ? FULL_SCALE - conv_result
                    : conv_result;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.sck_s   = {st_r.sck_s[1:0], sck};
        st_nxt.sen_s   = {st_r.sen_s[1:0], serial_load_strobe};
        st_nxt.sin_s   = {st_r.sin_s[0], serial_in};
        st_nxt.mode2_s = {st_r.mode2_s[0], mode2_select};

        // Serial shift-in on rising clock edges
        if (sck_rise)
        begin
            st_nxt.shift_in = {st_r.shift_in[SHIFT_W-2:0], st_r.sin_s[1]};
        end

        // Register writes
        if (srst_go)
        begin
            st_nxt.regs = REG_RST;
        end
        else if (wr_go)
        begin
            for (int i = 0; i < NREG; i++)
            begin
                if (cmd_addr == REG_ADDR[i])
                begin
                    st_nxt.regs[i] = cmd_data;
                end
                // Broadcast shares the upper address bits with its colours
                if ((cmd_addr == ADDR_AOFF || cmd_addr == ADDR_AGAIN)
                    && REG_ADDR[i][5:BCAST_LSB] == cmd_addr[5:BCAST_LSB])
                begin
                    st_nxt.regs[i] = cmd_data;
                end
            end
        end

        // Read-back: MSB shown at once, later bits on falling clock edges
        case (st_r.ser)
            AFECR_SER_IDLE:
            begin
                st_nxt.serial_out    = 1'b0;
                st_nxt.serial_out_oe = 1'b0;
            end
            AFECR_SER_READ:
            begin
                if (sck_fall)
                begin
                    if (st_r.out_cnt == READ_LAST_BIT)
                    begin
                        st_nxt.ser           = AFECR_SER_IDLE;
                        st_nxt.serial_out    = 1'b0;
                        st_nxt.serial_out_oe = 1'b0;
                    end
                    else
                    begin
                        st_nxt.shift_out  = {st_r.shift_out[6:0], 1'b0};
                        st_nxt.serial_out = st_r.shift_out[6];
                        st_nxt.out_cnt    = st_r.out_cnt + 4'h1;
                    end
                end
            end
            default:
            begin
                st_nxt.ser = AFECR_SER_IDLE;
            end
        endcase
        // A new request restarts the output even mid-word
        if (rd_go)
        begin
            st_nxt.ser           = AFECR_SER_READ;
            st_nxt.shift_out     = read_val;
            st_nxt.serial_out    = read_val[7];
            st_nxt.serial_out_oe = 1'b1;
            st_nxt.out_cnt       = 4'h0;
        end

        // ADC clock enable from the master clock
        if (st_r.adc_cnt >= adc_div - 2'h1)
        begin
            st_nxt.adc_cnt  = 2'h0;
            st_nxt.adc_tick = 1'b1;
        end
        else
        begin
            st_nxt.adc_cnt  = st_r.adc_cnt + 2'h1;
            st_nxt.adc_tick = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            st_r <= RST_STATE;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    afecr_latency_line #(
        .WIDTH (PIX_W),
        .DEPTH (3)
    ) u_line (
        .clk        (clk),
        .rst_n_sync (rst_n_sync),
        .shift_en   (st_r.adc_tick),
        .hold_zero  (~st_r.regs[IDX_PWR][PWR_EN_BIT]),
        .sel        (st_r.regs[IDX_OUT][OUT_LAT_LSB +: 2]),
        .din        (line_din),
        .dout       (pixel_data)
    );

    assign serial_out             = st_r.serial_out;
    assign serial_out_oe          = st_r.serial_out_oe;
    assign power_enable           = st_r.regs[IDX_PWR][PWR_EN_BIT];
    assign dual_sample_select     = st_r.regs[IDX_PWR][PWR_DUAL_BIT];
    assign amp_output_offset_sel  = st_r.regs[IDX_PWR][PWR_OFS_LSB +: 2];
    assign max_speed_mode_sel     = st_r.regs[IDX_PWR][PWR_MAX_BIT];
    assign output_polarity_invert = st_r.regs[IDX_OUT][OUT_INV_BIT];
    assign clamp_ref_external     = st_r.regs[IDX_OUT][OUT_EXT_BIT];
    assign clamp_dac_range        = st_r.regs[IDX_OUT][OUT_RNG_BIT];
    assign output_latency_sel     = st_r.regs[IDX_OUT][OUT_LAT_LSB +: 2];
    assign clamp_level_code       = st_r.regs[IDX_CLAMP][CLAMP_LVL_LSB +: 4];
    assign red_offset_code        = st_r.regs[IDX_ROFF];
    assign green_offset_code      = st_r.regs[IDX_GOFF];
    assign blue_offset_code       = st_r.regs[IDX_BOFF];
    assign red_gain_code          = st_r.regs[IDX_RGAIN];
    assign green_gain_code        = st_r.regs[IDX_GGAIN];
    assign blue_gain_code         = st_r.regs[IDX_BGAIN];
    assign adc_tick               = st_r.adc_tick;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n_sync);

    property p_write_applies;
        wr_go && cmd_addr == ADDR_PWR |=> st_r.regs[IDX_PWR] == $past(cmd_data);
    endproperty
    a_write_applies: assert property (p_write_applies) else $error("write not applied");

    property p_soft_reset;
        srst_go |=> power_enable && dual_sample_select && red_offset_code == RST_OFF
                    && output_latency_sel == 2'h0 && clamp_dac_range;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset missed");

    property p_power_down;
        !power_enable |=> pixel_data == '0;
    endproperty
    a_power_down: assert property (p_power_down) else $error("data while powered down");

    property p_invert;
        output_polarity_invert |-> line_din + conv_result == FULL_SCALE;
    endproperty
    a_invert: assert property (p_invert) else $error("inversion wrong");

    property p_no_latency;
        power_enable && output_latency_sel == 2'h0 |=> pixel_data == $past(line_din);
    endproperty
    a_no_latency: assert property (p_no_latency) else $error("minimum latency wrong");

    sequence s_gap_normal;
        !adc_tick ##1 adc_tick;
    endsequence
    sequence s_gap_mode2;
        !adc_tick [*2] ##1 adc_tick;
    endsequence
    property p_adc_mode2;
        adc_tick && st_r.mode2_s[1] && st_r.mode2_s[0] && mode2_select |=> s_gap_mode2;
    endproperty
    a_adc_mode2: assert property (p_adc_mode2) else $error("ADC period not three");

    property p_adc_normal;
        adc_tick && !st_r.mode2_s[1] && !st_r.mode2_s[0] && !mode2_select |=> s_gap_normal;
    endproperty
    a_adc_normal: assert property (p_adc_normal) else $error("ADC period not two clocks");

    property p_readback_start;
        rd_go |=> serial_out_oe && serial_out == $past(read_val[7]);
    endproperty
    a_readback_start: assert property (p_readback_start) else $error("read-back start wrong");

    property p_readback_end;
        st_r.ser == AFECR_SER_READ && sck_fall && st_r.out_cnt == READ_LAST_BIT && !rd_go
            |=> !serial_out_oe;
    endproperty
    a_readback_end: assert property (p_readback_end) else $error("read-back length wrong");

    property p_broadcast;
        wr_go && cmd_addr == ADDR_AGAIN |=> red_gain_code == $past(cmd_data)
            && green_gain_code == red_gain_code && blue_gain_code == red_gain_code;
    endproperty
    a_broadcast: assert property (p_broadcast) else $error("broadcast write wrong");

    property p_bcast_offset;
        wr_go && cmd_addr == ADDR_AOFF |=> red_offset_code == $past(cmd_data)
            && green_offset_code == red_offset_code && blue_offset_code == red_offset_code;
    endproperty
    a_bcast_offset: assert property (p_bcast_offset) else $error("offset broadcast wrong");

    property p_max_speed_mode_sel_bit;
        wr_go && cmd_addr == ADDR_PWR |=> max_speed_mode_sel == $past(cmd_data[PWR_MAX_BIT]);
    endproperty
    a_max_speed_mode_sel_bit: assert property (p_max_speed_mode_sel_bit) else $error("max speed bit wrong");

endmodule
`default_nettype wire

// *** test/afecr_host_model.sv ***
// Host model: serial controller that writes and reads back the control bank.
// Assumes clk is the bank's master clock; every pin moves at its falling edge.
`timescale 1ns/1ns
`default_nettype none
module afecr_host_model (
    input  wire logic clk,
    input  wire logic serial_out,
    output logic      sck,
    output logic      serial_in,
    output logic      serial_load_strobe
);
    initial
    begin
        sck = 1'h0;
        serial_in = 1'h0;
        serial_load_strobe = 1'h0;
    end

    task automatic hold(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Each level lasts four master clocks so the bank's synchroniser sees it
    task automatic send(input logic [5:0] addr, input logic [7:0] data);
        logic [13:0] word;
        word = {addr, data};
        for (int i = 13; i >= 0; i--)
        begin
            serial_in = word[i];
            hold(4);
            sck = 1'h1;
            hold(4);
            sck = 1'h0;
        end
        hold(4);
        serial_load_strobe = 1'h1;
        hold(4);
        serial_load_strobe = 1'h0;
        // Data line is meaningless after the word, so do not leave the last bit on it
        serial_in = ~serial_in;
        hold(4);
    endtask

    task automatic read(input logic [5:0] addr, output logic [7:0] data);
        send(addr | 6'h10, 8'h00);
        data[7] = serial_out;
        for (int i = 6; i >= -1; i--)
        begin
            sck = 1'h1;
            hold(4);
            sck = 1'h0;
            // Bank shows the next bit about three clocks after the fall; four keeps 400 ns
            hold(4);
            if (i >= 0)
                data[i] = serial_out;
        end
    endtask
endmodule
`default_nettype wire

// *** test/test_afe_control_register_bank.sv ***
// Self-checking bench for the control register bank of the imaging front end.
// Assumes the host model drives the serial pins; the bench drives the rest.
`timescale 1ns/1ns
`default_nettype none
module test_afe_control_register_bank
    import afecr_pkg::*;
;
    localparam logic [7:0] REV = 8'h3C;  // Arbitrary value
    logic             clk, rst_b, mode2_select, sck, serial_in, serial_load_strobe;
    logic             serial_out, serial_out_oe, power_enable, dual_sample_select;
    logic             max_speed_mode_sel, output_polarity_invert, clamp_ref_external;
    logic             clamp_dac_range, adc_tick;
    logic [1:0]       amp_output_offset_sel, output_latency_sel;
    logic [3:0]       clamp_level_code;
    logic [7:0]       red_offset_code, green_offset_code, blue_offset_code, d;
    logic [7:0]       red_gain_code, green_gain_code, blue_gain_code;
    logic [PIX_W-1:0] conv_result, pixel_data;
    int               failures, checked, n;
    int               cycles = 0;

    afecr_control_bank #(.REVISION_ID(REV)) DUT (
        .clk, .rst_b, .sck, .serial_in, .serial_load_strobe, .mode2_select, .conv_result,
        .serial_out, .serial_out_oe, .power_enable, .dual_sample_select,
        .amp_output_offset_sel, .max_speed_mode_sel, .output_polarity_invert,
        .clamp_ref_external, .clamp_dac_range, .output_latency_sel, .clamp_level_code,
        .red_offset_code, .green_offset_code, .blue_offset_code, .red_gain_code,
        .green_gain_code, .blue_gain_code, .adc_tick, .pixel_data
    );
    afecr_host_model u_host (.clk, .serial_out, .sck, .serial_in, .serial_load_strobe);

    task automatic close_out();
        if (failures == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic to_tick();
        for (int k = 0; k < 4 && adc_tick !== 1'h1; k++)
            @(negedge clk);
    endtask

    task automatic t_defaults();
        logic [5:0] a [10] = '{ADDR_PWR, ADDR_OUT, ADDR_CLAMP, ADDR_CCOL, ADDR_REV,
                               ADDR_ROFF, ADDR_RGAIN, ADDR_AOFF, ADDR_SRST, 6'h3F};
        logic [7:0] e [10] = '{8'h0F, 8'h23, 8'h1F, 8'h05, REV, 8'h80, 8'h00, 8'h00,
                               8'h00, 8'h00};
        u_host.send(ADDR_SRST, 8'h00);
        check(power_enable, 1'h1);
        check(dual_sample_select, 1'h1);
        check(amp_output_offset_sel, 2'h0);
        check(max_speed_mode_sel, 1'h0);
        check(output_polarity_invert, 1'h0);
        check(clamp_ref_external, 1'h0);
        check(clamp_dac_range, 1'h1);
        check(output_latency_sel, 2'h0);
        for (int i = 0; i < 10; i++)
        begin
            u_host.read(a[i], d);
            check(d, e[i]);
            check(serial_out_oe, 1'h0);
        end
    endtask

    task automatic t_power();
        u_host.send(ADDR_PWR, 8'h0D);
        check(power_enable, 1'h1);
        check(dual_sample_select, 1'h0);
        for (int c = 0; c < 4; c++)
        begin
            u_host.send(ADDR_PWR, {2'h1, c[1:0], 4'hC});
            check(amp_output_offset_sel, c[1:0]);
            check(max_speed_mode_sel, 1'h1);
            check(power_enable, 1'h0);
            check(pixel_data, 16'h0000);
        end
        u_host.send(ADDR_PWR, 8'h0F);
        check(power_enable, 1'h1);
    endtask

    task automatic t_invert();
        u_host.send(ADDR_OUT, 8'h0F);
        check(output_polarity_invert, 1'h1);
        check(clamp_ref_external, 1'h1);
        check(clamp_dac_range, 1'h0);
        check(pixel_data, FULL_SCALE - 16'h1234);
        u_host.send(ADDR_OUT, 8'h23);
        check(pixel_data, 16'h1234);
    endtask

    // New sample arrives at a tick; the first latency step costs one master clock, each later step one ADC period
    task automatic t_latency();
        int l;
        for (int i = 0; i < 4; i++)
        begin
            l = (i + 1) % 4;
            u_host.send(ADDR_OUT, {l[1:0], 6'h23});
            check(output_latency_sel, l[1:0]);
            conv_result = 16'h0000;
            repeat (12) @(negedge clk);
            to_tick();
            conv_result = 16'hBEEF;
            n = 0;
            while (pixel_data !== 16'hBEEF && n < 30)
            begin
                @(negedge clk);
                n++;
            end
            check(16'(n), 16'(l == 0 ? 1 : int'(ADC_DIV_NORMAL) * l));
        end
    endtask

    task automatic t_tick();
        for (int m = 0; m < 2; m++)
        begin
            mode2_select = m[0];
            repeat (10) @(negedge clk);
            to_tick();
            @(negedge clk);
            n = 1;
            while (adc_tick !== 1'h1 && n < 8)
            begin
                @(negedge clk);
                n++;
            end
            check(16'(n), m == 1 ? 16'h3 : 16'h2);
        end
        mode2_select = 1'h0;
    endtask

    task automatic t_broadcast();
        u_host.send(ADDR_AOFF, 8'h3C);
        check({red_offset_code, green_offset_code}, 16'h3C3C);
        check(blue_offset_code, 8'h3C);
        u_host.send(ADDR_AGAIN, 8'h91);
        check({red_gain_code, green_gain_code}, 16'h9191);
        check(blue_gain_code, 8'h91);
        u_host.send(ADDR_GOFF, 8'h11);
        check({red_offset_code, green_offset_code}, 16'h3C11);
        u_host.send(ADDR_CLAMP, 8'h1A);
        check(clamp_level_code, 4'hA);
        u_host.send(ADDR_REV, 8'h00);
        u_host.read(ADDR_REV, d);
        check(d, REV);
        u_host.read(ADDR_BOFF, d);
        check(d, 8'h3C);
    endtask

    task automatic t_soft_reset();
        u_host.send(ADDR_PWR, 8'h0C);
        u_host.send(ADDR_SRST, 8'hFF);
        check({red_offset_code, green_gain_code}, 16'h8000);
        check(clamp_level_code, 4'hF);
        check(power_enable, 1'h1);
        u_host.read(ADDR_OUT, d);
        check(d, 8'h23);
    endtask

    initial
    begin
        clk = 1'h0;
        rst_b = 1'h0;
        mode2_select = 1'h0;
        conv_result = 16'h1234;
        failures = 0;
        checked = 0;
        repeat (10) @(negedge clk);
        rst_b = 1'h1;
        repeat (6) @(negedge clk);
        t_defaults();
        t_power();
        t_invert();
        t_latency();
        t_tick();
        t_broadcast();
        t_soft_reset();
        close_out();
    end

    always #50 clk = ~clk;

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures++;
            close_out();
        end
    end
endmodule
`default_nettype wire
